// [src/rivu_top.v]
// Reset and interrupt vector unit with nonvolatile configuration
//
// Operation
// - Four config bits nonvolatile, upper bits zero
// - Erased config cells read as 0x0F
// - New config visible only after reset
// - Config changes allowed only in special mode
// - Single-chip reset forces ROM enable on
// - ROM enable bit maps the ROM
// - EEPROM enable bit maps the EEPROM
// - Three reset vectors plus interrupt vectors
// - Illegal opcode, software non-maskable; pseudo pin gated by X mask
// - Maskable sources need global mask clear
// - Local enables gate all but pin
// - Fixed priority with one promoted source
// - Status then data read clears receive-full
// - Periodic tick interrupts gated by enable
// - Tick rate from two-bit field
// - Async serial sources share one vector
// - Sync serial and pulse vectors, own enables
// - Timer overflow and channel vectors ascending
// - Pseudo pin, software, illegal opcode vectors
// - Watchdog, monitor and external reset vectors
// - Watchdog disable suppresses timeout reset
// - Four-bit code selects promoted source
`timescale 1ns/1ps
`include "rivu_map.vh"

module rivu_top #(
	parameter TICK_BASE = `RIVU_TICK_BASE_CYCLES,
	parameter ADDR_W    = 16
) (
	input  wire              clk_sys,
	input  wire              rst_n,
	input  wire              porN,           // Power-on reset, cells
	// AXI4-Lite slave
	input  wire [ADDR_W-1:0] s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output reg               s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output reg               s_axi_wready,
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [ADDR_W-1:0] s_axi_araddr,
	input  wire              s_axi_arvalid,
	output reg               s_axi_arready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	// Pins
	input  wire              modeB,
	input  wire              modeA,
	input  wire              irqPinN,
	input  wire              pseudoNmiPinN,
	// Core side
	input  wire              ccrIMask,
	input  wire              ccrXMask,
	input  wire              swiReq,
	input  wire              illegalOpReq,
	input  wire              vectorAck,
	// Peripheral flags
	input  wire              txComplete,
	input  wire              txEmpty,
	input  wire              idleLine,
	input  wire              rxOverrun,
	input  wire              rxFullSet,
	input  wire [7:0]        rxData,
	input  wire              syncSerialDone,
	input  wire              pulseEdge,
	input  wire              pulseOverflow,
	input  wire              timerOverflow,
	input  wire [7:0]        timerChanFlags, // 0 = cap4/cmp5 .. 7 = cap1
	input  wire              handshakeFlag,
	input  wire              watchdogTimeout,
	input  wire              clockFail,
	// Outputs
	output reg  [15:0]       vectorAddr,
	output reg               vectorValid,
	output reg               resetReq,
	output wire              romMapEnable,
	output wire              eepromMapEnable,
	output wire              eepromSecurityDisable,
	output wire              watchdogDisable
);

	// ======================================================================
	// Declarations
	localparam [1:0] SEQ_SYNC = 2'd0;  // Let mode pins settle
	localparam [1:0] SEQ_LOAD = 2'd1;  // Latch config and mode
	localparam [1:0] SEQ_RUN  = 2'd2;  // Normal operation
	localparam       NSRC     = 15;    // Maskable vectors

	reg  [1:0]  syncMode1_reg, syncMode2_reg;  // Mode pin synchroniser
	reg  [1:0]  syncPin1_reg,  syncPin2_reg;   // Irq pins synchroniser
	reg  [1:0]  seqState_reg;                  // Reset sequence
	reg  [1:0]  seqCnt_reg;                    // Settle counter
	reg  [3:0]  nvCells_reg;                   // Nonvolatile cells
	reg  [3:0]  cfgLatch_reg;                  // Visible config
	reg  [2:0]  modeLatch_reg;                 // Boot, special, mode A
	reg  [3:0]  prioSel_reg;                   // Promotion code
	reg  [1:0]  tickRate_reg;                  // Tick rate field
	reg  [18:0] enables_reg;                   // Local enables
	reg         tickFlag_reg;                  // Periodic tick flag
	reg         rxFull_reg;                    // Receive-full flag
	reg         rxArmed_reg;                   // Status read seen
	reg         causeExt_reg, causeCop_reg, causeCm_reg;
	reg         awHeld_reg, wHeld_reg;         // Write halves taken
	reg  [13:0] awIdx_reg;                     // Held write index
	reg  [31:0] wData_reg;                     // Held write data
	reg  [3:0]  wStrb_reg;                     // Held strobes
	reg  [31:0] rdNext;                        // Read mux
	reg         rdErr;                         // Unmapped read
	reg  [15:0] vecNext;                       // Next vector
	reg         vecValidNext;
	wire [13:0] arIdx;
	wire        doWrite, wrOk, rdTake;
	wire        specialMode, irqAsserted, xirqAsserted;
	wire        tickPulse, encFound;
	wire [3:0]  encIdx;
	wire [NSRC-1:0] reqRaw, reqEn, pending;
	wire        copFire, cmFire;

	assign arIdx        = s_axi_araddr[15:2];
	assign doWrite      = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
	assign rdTake       = s_axi_arvalid & s_axi_arready;
	assign specialMode  = modeLatch_reg[1];
	assign irqAsserted  = ~syncPin2_reg[0];
	assign xirqAsserted = ~syncPin2_reg[1];

	// ROM decode follows the latched bit
	assign romMapEnable          = cfgLatch_reg[`RIVU_CFG_ROM_BIT];
	// EEPROM decode follows the latched bit
	assign eepromMapEnable       = cfgLatch_reg[`RIVU_CFG_EE_BIT];
	assign eepromSecurityDisable = cfgLatch_reg[`RIVU_CFG_SEC_BIT];
	assign watchdogDisable       = cfgLatch_reg[`RIVU_CFG_WDOG_BIT];

	// ======================================================================
	// Pin synchronisers; first stages feed only second stages
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			syncMode1_reg <= 2'h0;
			syncMode2_reg <= 2'h0;
			syncPin1_reg  <= 2'h3;
			syncPin2_reg  <= 2'h3;
		end
		else
		begin
			syncMode1_reg <= {modeB, modeA};
			syncMode2_reg <= syncMode1_reg;
			syncPin1_reg  <= {pseudoNmiPinN, irqPinN};
			syncPin2_reg  <= syncPin1_reg;
		end
	end

	// ======================================================================
	// Nonvolatile cells survive functional resets
	always @(posedge clk_sys or negedge porN)
	begin
		if (!porN)
			nvCells_reg <= `RIVU_CFG_ERASED;
		else if (doWrite && wrOk && specialMode && wStrb_reg[0] &&
			awIdx_reg == `RIVU_IDX_CONFIG)
			nvCells_reg <= wData_reg[3:0];
	end

	// ======================================================================
	// Reset sequence: mode pins and cells latched after release
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			seqState_reg  <= SEQ_SYNC;
			seqCnt_reg    <= 2'h0;
			cfgLatch_reg  <= `RIVU_CFG_ERASED;
			modeLatch_reg <= 3'h0;
		end
		else
		begin
			case (seqState_reg)
				SEQ_SYNC:
				begin
					seqCnt_reg <= seqCnt_reg + 2'h1;
					if (seqCnt_reg == `RIVU_SYNC_SETTLE)
						seqState_reg <= SEQ_LOAD;
				end
				SEQ_LOAD:
				begin
					cfgLatch_reg <= nvCells_reg;
					if (syncMode2_reg == 2'b10)
						cfgLatch_reg[`RIVU_CFG_ROM_BIT] <= 1'b1;
					modeLatch_reg <= {~syncMode2_reg[1] & ~syncMode2_reg[0],
						~syncMode2_reg[1], syncMode2_reg[0]};
					seqState_reg  <= SEQ_RUN;
				end
				default:
					seqState_reg <= SEQ_RUN;
			endcase
		end
	end

	// ======================================================================
	// Watchdog and clock monitor reset causes, kept across rst_n
	// Timeout resets only when not disabled
	assign copFire = watchdogTimeout & ~watchdogDisable &
		(seqState_reg == SEQ_RUN);
	assign cmFire  = clockFail & enables_reg[`RIVU_EN_CME_BIT] &
		(seqState_reg == SEQ_RUN);

	always @(posedge clk_sys or negedge porN)
	begin
		if (!porN)
		begin
			causeCop_reg <= 1'b0;
			causeCm_reg  <= 1'b0;
		end
		else
		begin
			// New failure wins over the fetch that clears it
			causeCop_reg <= copFire |
				(causeCop_reg & ~(vectorAck && vectorAddr == `RIVU_VEC_WDOG));
			causeCm_reg  <= cmFire |
				(causeCm_reg & ~(vectorAck && vectorAddr == `RIVU_VEC_CLKMON));
		end
	end

	// ======================================================================
	// External reset cause and reset request
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			causeExt_reg <= 1'b0;
			resetReq     <= 1'b0;
		end
		else
		begin
			// Plain reset unless a failure caused it
			if (seqState_reg == SEQ_LOAD)
				causeExt_reg <= ~causeCop_reg & ~causeCm_reg;
			else if (vectorAck && vectorAddr == `RIVU_VEC_RESET)
				causeExt_reg <= 1'b0;
			// Held until the system applies rst_n
			if (copFire || cmFire)
				resetReq <= 1'b1;
		end
	end

	// ======================================================================
	// Maskable sources and their local enables
	// Async serial sources share one vector
	assign reqRaw[0]  = (txComplete & enables_reg[`RIVU_EN_TX_COMPLETE_ENABLE_BIT]) |
		(txEmpty & enables_reg[`RIVU_EN_TIE_BIT]) |
		(idleLine & enables_reg[`RIVU_EN_IDLE_LINE_ENABLE_BIT]) |
		((rxOverrun | rxFull_reg) & enables_reg[`RIVU_EN_RIE_BIT]);
	assign reqEn[0]   = 1'b1;
	assign reqRaw[3:1] = {pulseOverflow, pulseEdge, syncSerialDone};
	assign reqEn[3:1]  = {enables_reg[`RIVU_EN_PULSE_OVERFLOW_IRQ_ENABLE_BIT],
		enables_reg[`RIVU_EN_PULSE_EDGE_IRQ_ENABLE_BIT], enables_reg[`RIVU_EN_SYNC_SERIAL_IRQ_ENABLE_BIT]};
	assign reqRaw[12:4] = {timerChanFlags, timerOverflow};
	assign reqEn[12:4]  = {enables_reg[7:0], enables_reg[`RIVU_EN_TOI_BIT]};
	// Tick flag gated by its enable
	assign reqRaw[13] = tickFlag_reg;
	assign reqEn[13]  = enables_reg[`RIVU_EN_TICK_IRQ_ENABLE_BIT];
	assign reqRaw[14] = irqAsserted |
		(handshakeFlag & enables_reg[`RIVU_EN_HANDSHAKE_IRQ_ENABLE_BIT]);
	assign reqEn[14]  = 1'b1;

	// Per-vector gating
	genvar g;
	generate
		for (g = 0; g < NSRC; g = g + 1)
		begin : gen_gate
			assign pending[g] = reqRaw[g] & reqEn[g];
		end
	endgenerate

	rivu_prio_enc #(
		.N        (NSRC)
	) u_prio (
		.pending  (pending),
		.promoSel (prioSel_reg),
		.found    (encFound),
		.winIdx   (encIdx)
	);

	rivu_tick_gen #(
		.TICK_BASE (TICK_BASE)
	) u_tick (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.rateSel   (tickRate_reg),
		.tickPulse (tickPulse)
	);

	// ======================================================================
	// Vector selection, resets first
	always @*
	begin
		vecValidNext = 1'b1;
		vecNext      = `RIVU_VEC_RESET;
		if (causeExt_reg)
			vecNext = `RIVU_VEC_RESET;
		else if (causeCm_reg)
			vecNext = `RIVU_VEC_CLKMON;
		else if (causeCop_reg)
			vecNext = `RIVU_VEC_WDOG;
		else if (illegalOpReq)
			vecNext = `RIVU_VEC_ILLOP;
		else if (swiReq)
			vecNext = `RIVU_VEC_SWI;
		// Pseudo pin gated by X mask
		else if (xirqAsserted && !ccrXMask)
			vecNext = `RIVU_VEC_PSEUDO_NMI_PIN;
		else if (encFound && !ccrIMask)
			vecNext = `RIVU_VEC_MASK_BASE + {11'h000, encIdx, 1'b0};
		else
			vecValidNext = 1'b0;
	end

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			vectorAddr  <= `RIVU_VEC_RESET;
			vectorValid <= 1'b0;
		end
		else
		begin
			// Nothing offered until the sequence has latched
			vectorAddr  <= vecNext;
			vectorValid <= vecValidNext & (seqState_reg == SEQ_RUN);
		end
	end

	// ======================================================================
	// AXI4-Lite write channels, taken in either order
	assign wrOk = (awIdx_reg == `RIVU_IDX_CONFIG) ||
		(awIdx_reg == `RIVU_IDX_PRIO) ||
		(awIdx_reg == `RIVU_IDX_PULSE_CTL) ||
		(awIdx_reg == `RIVU_IDX_TICK_FLAG) ||
		(awIdx_reg == `RIVU_IDX_ENABLES);

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			awHeld_reg    <= 1'b0;
			wHeld_reg     <= 1'b0;
			awIdx_reg     <= 14'h0000;
			wData_reg     <= 32'h00000000;
			wStrb_reg     <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awIdx_reg     <= s_axi_awaddr[15:2];
				awHeld_reg    <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wData_reg    <= s_axi_wdata;
				wStrb_reg    <= s_axi_wstrb;
				wHeld_reg    <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (doWrite)
			begin
				awHeld_reg   <= 1'b0;
				wHeld_reg    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrOk ? 2'b00 : 2'b10;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ======================================================================
	// Software-written control registers
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prioSel_reg  <= `RIVU_PRIO_RESET;
			tickRate_reg <= 2'h0;
			enables_reg  <= `RIVU_EN_RESET;
		end
		else if (doWrite)
		begin
			if (awIdx_reg == `RIVU_IDX_PRIO)
			begin
				if (ccrIMask && wStrb_reg[0])
					prioSel_reg <= wData_reg[3:0];
			end
			else if (awIdx_reg == `RIVU_IDX_PULSE_CTL)
			begin
				if (wStrb_reg[0])
					tickRate_reg <= wData_reg[1:0];
			end
			else if (awIdx_reg == `RIVU_IDX_ENABLES)
			begin
				if (wStrb_reg[0])
					enables_reg[7:0] <= wData_reg[7:0];
				if (wStrb_reg[1])
					enables_reg[15:8] <= wData_reg[15:8];
				if (wStrb_reg[2])
					enables_reg[18:16] <= wData_reg[18:16];
			end
		end
	end

	// ======================================================================
	// Hardware-set flags; a set in the clearing cycle wins
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tickFlag_reg <= 1'b0;
			rxFull_reg   <= 1'b0;
			rxArmed_reg  <= 1'b0;
		end
		else
		begin
			// Write one to clear the tick flag
			if (tickPulse)
				tickFlag_reg <= 1'b1;
			else if (doWrite && awIdx_reg == `RIVU_IDX_TICK_FLAG &&
				wStrb_reg[0] && wData_reg[`RIVU_TICK_FLAG_BIT])
				tickFlag_reg <= 1'b0;
			// Status read arms, data read clears
			if (rxFullSet)
			begin
				rxFull_reg  <= 1'b1;
				rxArmed_reg <= 1'b0;
			end
			else if (rdTake && arIdx == `RIVU_IDX_SCI_STAT && rxFull_reg)
				rxArmed_reg <= 1'b1;
			else if (rdTake && arIdx == `RIVU_IDX_SCI_DATA && rxArmed_reg)
			begin
				rxFull_reg  <= 1'b0;
				rxArmed_reg <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Read decode
	always @*
	begin
		rdNext = 32'h00000000;
		rdErr  = 1'b0;
		if (arIdx == `RIVU_IDX_CONFIG)
			rdNext[3:0] = cfgLatch_reg;
		else if (arIdx == `RIVU_IDX_PRIO)
			rdNext[7:0] = {modeLatch_reg, 1'b0, prioSel_reg};
		else if (arIdx == `RIVU_IDX_PULSE_CTL)
			rdNext[1:0] = tickRate_reg;
		else if (arIdx == `RIVU_IDX_TICK_FLAG)
			rdNext[`RIVU_TICK_FLAG_BIT] = tickFlag_reg;
		else if (arIdx == `RIVU_IDX_SCI_STAT)
			rdNext[`RIVU_RX_FULL_BIT] = rxFull_reg;
		else if (arIdx == `RIVU_IDX_SCI_DATA)
			rdNext[7:0] = rxData;
		else if (arIdx == `RIVU_IDX_ENABLES)
			rdNext[18:0] = enables_reg;
		else if (arIdx == `RIVU_IDX_PENDING)
			rdNext[15:0] = {encFound, pending};
		else if (arIdx == `RIVU_IDX_VECTOR)
			rdNext[16:0] = {vectorValid, vectorAddr};
		else
			rdErr = 1'b1;
	end

	// AXI4-Lite read channel, one read at a time
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= 2'b00;
		end
		else if (rdTake)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rdNext;
			s_axi_rresp   <= rdErr ? 2'b10 : 2'b00;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule // rivu_top

// [inc/rivu_map.vh]
// Register indices, field positions, reset values and counts of the unit
`ifndef RIVU_MAP_VH
`define RIVU_MAP_VH

// ==========================================================================
// Register indices (byte address is four times the index)
`define RIVU_IDX_CONFIG     14'h103F
`define RIVU_IDX_PRIO       14'h103C
`define RIVU_IDX_PULSE_CTL  14'h1026
`define RIVU_IDX_TICK_FLAG  14'h1025
`define RIVU_IDX_SCI_STAT   14'h102E
`define RIVU_IDX_SCI_DATA   14'h102F
`define RIVU_IDX_ENABLES    14'h1040
`define RIVU_IDX_PENDING    14'h1041
`define RIVU_IDX_VECTOR     14'h1042

// ==========================================================================
// Field positions
`define RIVU_CFG_SEC_BIT    3
`define RIVU_CFG_WDOG_BIT   2
`define RIVU_CFG_ROM_BIT    1
`define RIVU_CFG_EE_BIT     0
`define RIVU_TICK_FLAG_BIT  6
`define RIVU_RX_FULL_BIT    5
`define RIVU_EN_TOI_BIT     8
`define RIVU_EN_TICK_IRQ_ENABLE_BIT    9
`define RIVU_EN_PULSE_OVERFLOW_IRQ_ENABLE_BIT   10
`define RIVU_EN_PULSE_EDGE_IRQ_ENABLE_BIT    11
`define RIVU_EN_SYNC_SERIAL_IRQ_ENABLE_BIT    12
`define RIVU_EN_TIE_BIT     13
`define RIVU_EN_TX_COMPLETE_ENABLE_BIT    14
`define RIVU_EN_RIE_BIT     15
`define RIVU_EN_IDLE_LINE_ENABLE_BIT    16
`define RIVU_EN_HANDSHAKE_IRQ_ENABLE_BIT    17
`define RIVU_EN_CME_BIT     18

// ==========================================================================
// Reset values
`define RIVU_CFG_ERASED     4'hF
`define RIVU_PRIO_RESET     4'h5
`define RIVU_EN_RESET       19'h00000

// ==========================================================================
// Vector addresses
`define RIVU_VEC_MASK_BASE  16'hFFD6
`define RIVU_VEC_PSEUDO_NMI_PIN       16'hFFF4
`define RIVU_VEC_SWI        16'hFFF6
`define RIVU_VEC_ILLOP      16'hFFF8
`define RIVU_VEC_WDOG       16'hFFFA
`define RIVU_VEC_CLKMON     16'hFFFC
`define RIVU_VEC_RESET      16'hFFFE

// ==========================================================================
// Timing counts
`define RIVU_TICK_BASE_CYCLES 8192
`define RIVU_SYNC_SETTLE      2'd2

`endif

// [src/rivu_tick_gen.v]
// Periodic tick generator with a two-bit rate select
`timescale 1ns/1ps
`include "rivu_map.vh"

module rivu_tick_gen #(
	parameter TICK_BASE = `RIVU_TICK_BASE_CYCLES,
	parameter CNT_W     = 16
) (
	input  wire       clk_sys,
	input  wire       rst_n,
	input  wire [1:0] rateSel,
	output reg        tickPulse
);

	// Last count of the base prescaler, cut to the counter width
	localparam integer     BASE_LAST_I = TICK_BASE - 1;
	localparam [CNT_W-1:0] BASE_LAST   = BASE_LAST_I[CNT_W-1:0];

	reg  [CNT_W-1:0] baseCnt_reg;   // Base prescaler
	reg  [2:0]       rateCnt_reg;   // Counts base periods
	wire [2:0]       rateLast;      // 0, 1, 3 or 7
	wire             baseEnd;       // End of one base period

	assign rateLast = (3'h1 << rateSel) - 3'h1;
	assign baseEnd  = (baseCnt_reg == BASE_LAST);

	// ======================================================================
	// Prescaler chain; period is the base times 1, 2, 4 or 8
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			baseCnt_reg <= {CNT_W{1'b0}};
			rateCnt_reg <= 3'h0;
			tickPulse   <= 1'b0;
		end
		else
		begin
			tickPulse <= 1'b0;
			if (baseEnd)
			begin
				baseCnt_reg <= {CNT_W{1'b0}};
				// Rate changes take effect at the next base period
				if (rateCnt_reg >= rateLast)
				begin
					rateCnt_reg <= 3'h0;
					tickPulse   <= 1'b1;
				end
				else
					rateCnt_reg <= rateCnt_reg + 3'h1;
			end
			else
				baseCnt_reg <= baseCnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

endmodule // rivu_tick_gen

// [src/rivu_prio_enc.v]
// Maskable priority encoder with one promotable source
`timescale 1ns/1ps

module rivu_prio_enc #(
	parameter N = 15
) (
	input  wire [N-1:0] pending,
	input  wire [3:0]   promoSel,
	output reg          found,
	output reg  [3:0]   winIdx
);

	// Map of the promotion code onto a vector index
	function [3:0] promoIdx;
		input [3:0] sel;
		begin
			case (sel)
				4'h0:    promoIdx = 4'h4;  // Timer overflow
				4'h1:    promoIdx = 4'h3;  // Pulse overflow
				4'h2:    promoIdx = 4'h2;  // Pulse edge
				4'h3:    promoIdx = 4'h1;  // Sync serial
				4'h4:    promoIdx = 4'h0;  // Async serial
				4'h5:    promoIdx = 4'hE;  // Reserved, behaves as pin
				4'h6:    promoIdx = 4'hE;  // External pin
				4'h7:    promoIdx = 4'hD;  // Periodic tick
				// Timer channels: 20 minus code, wrapped to four bits
				default: promoIdx = 4'h4 - sel;
			endcase
		end
	endfunction

	reg [3:0] pIdx;   // Promoted index
	integer   i;

	// ======================================================================
	// Scan upward so the highest vector address wins
	always @*
	begin
		pIdx   = promoIdx(promoSel);
		found  = 1'b0;
		winIdx = 4'h0;
		for (i = 0; i < N; i = i + 1)
		begin
			if (pending[i])
			begin
				found  = 1'b1;
				winIdx = i[3:0];
			end
		end
		if (pending[pIdx])
			winIdx = pIdx;
	end

endmodule // rivu_prio_enc

// [sim/rivu_core_model.sv]
// Core model that fetches each vector the unit offers
`timescale 1ns/1ps
module rivu_core_model (
	input  wire logic clk_sys,
	input  wire logic ackOn,
	input  wire logic vectorValid,
	output logic      vectorAck
);
	// ====
	// Fetch pulse, then a gap, as a real stacking sequence would leave
	initial vectorAck = 1'b0;
	always @(posedge clk_sys)
		vectorAck <= ackOn && vectorValid && !vectorAck;
endmodule // rivu_core_model

// [sim/rivu_top_assertions.sv]
// Checker for vector choice, reset causes and bus answers
`timescale 1ns/1ps
module rivu_top_assertions (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        ccrIMask,
	input wire logic        illegalOpReq,
	input wire logic        watchdogTimeout,
	input wire logic        watchdogDisable,
	input wire logic        clockFail,
	input wire logic        resetReq,
	input wire logic [15:0] vectorAddr,
	input wire logic        vectorValid,
	input wire logic        romMapEnable,
	input wire logic        eepromMapEnable,
	input wire logic        eepromSecurityDisable
);
	// ====
	// Properties
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_illop_vec: assert property (illegalOpReq |=>
		vectorAddr == 16'hFFF8 || vectorAddr > 16'hFFF9) else $error("bad trap");
	a_imask_gate: assert property (ccrIMask |=>
		!(vectorValid && vectorAddr < 16'hFFF4)) else $error("mask leak");
	a_wdog_cause: assert property ($rose(resetReq) |->
		$past(clockFail) || $past(watchdogTimeout) && !$past(watchdogDisable))
		else $error("spurious reset");
	a_cause_held: assert property (resetReq |=> resetReq)
		else $error("cause lost");
	a_cfg_frozen: assert property ($past(rst_n, 7) |->
		$stable({romMapEnable, eepromMapEnable, eepromSecurityDisable,
		watchdogDisable})) else $error("config moved");
	a_vec_range: assert property (vectorValid |->
		!vectorAddr[0] && vectorAddr >= 16'hFFD6) else $error("bad vector");
	a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("response repeated");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read late");
	c_wdog: cover property (resetReq);
	c_top: cover property (vectorValid && vectorAddr == 16'hFFEE);
	c_read: cover property (s_axi_rvalid);
endmodule // rivu_top_assertions
bind rivu_top rivu_top_assertions u_chk (.*);

// [sim/test_rivu_top.sv]
// Bench for the reset and interrupt vector unit
`timescale 1ns/1ps
`define CHK(g, e) bump((g) !== (e))
module test_rivu_top;
	logic clk_sys = 0, rst_n = 0, porN = 0, modeB = 0, modeA = 1, ackOn = 1;
	logic irqPinN, pseudoNmiPinN, ccrIMask, ccrXMask, swiReq, illegalOpReq;
	logic txComplete, txEmpty, idleLine, rxOverrun, syncSerialDone;
	logic pulseEdge, pulseOverflow, timerOverflow, handshakeFlag, vectorAck;
	logic rxFullSet = 0, watchdogTimeout = 0, clockFail = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, vectorValid, resetReq;
	logic romMapEnable, eepromMapEnable, eepromSecurityDisable;
	logic watchdogDisable;
	wire [3:0]   cfgPins = {eepromSecurityDisable, watchdogDisable,
		romMapEnable, eepromMapEnable};
	logic [7:0]  timerChanFlags, rxData = 8'hA5;
	logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0, vectorAddr;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	int          errorCnt = 0, nTests = 0, i;
	// Flag pattern beside the vector it must raise
	logic [38:0] rows [14] = '{39'h710000FFD6, 39'h702000FFD6,
		39'h70C000FFD6, 39'h701000FFD8, 39'h700800FFDA, 39'h700400FFDC,
		39'h700200FFDE, 39'h700001FFE0, 39'h700281FFEE, 39'h700100FFF2,
		39'h300000FFF2, 39'h480080FFF4, 39'h7403FFFFF6, 39'h760000FFF8};
	rivu_top #(.TICK_BASE(8)) dut (.*);
	rivu_core_model u_core (.*);
	initial
	begin
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic bump(input bit bad);
		nTests++;
		if (bad)
		begin
			errorCnt++;
			$display("MISMATCH %0t value differs", $time);
		end
	endtask
	task automatic closeOut(input bit hang);
		if (hang) errorCnt++;
		if (errorCnt == 0 && nTests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic drv(input [22:0] f);
		{irqPinN, pseudoNmiPinN, ccrXMask, ccrIMask, swiReq, illegalOpReq,
			txComplete, txEmpty, idleLine, rxOverrun, syncSerialDone,
			pulseEdge, pulseOverflow, timerOverflow, handshakeFlag,
			timerChanFlags} <= f;
	endtask
	// One-cycle failure pulse: clock monitor if cm, else watchdog
	task automatic fail(input bit cm);
		clockFail <= cm;
		watchdogTimeout <= !cm;
		@(posedge clk_sys);
		clockFail <= 1'b0;
		watchdogTimeout <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
	// Reset with the given mode pins, then let the load sequence finish
	task automatic rst(input bit b, input bit a);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		modeB <= b;
		modeA <= a;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		porN <= 1'b1;
		repeat (8) @(posedge clk_sys);
	endtask
	// One bus transfer; each channel held until its own ready
	task automatic bus(input bit w, input [15:0] a, input [31:0] d);
		int k;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		for (k = 0; k < 40; k++)
		begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (w) rsp = s_axi_bresp;
			else {rsp, rd} = {s_axi_rresp, s_axi_rdata};
			if (w ? s_axi_bvalid : s_axi_rvalid) break;
		end
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		if (k == 40) closeOut(1'b1);
	endtask
	initial
	begin
		drv(23'h700000);
		rst(1'b0, 1'b1);
		bus(0, 16'h40FC, 0);
		`CHK(rd, 32'h0000000F);
		`CHK(cfgPins, 4'hF);
		bus(1, 16'h40FC, 0);
		bus(0, 16'h40FC, 0);
		`CHK(rd, 32'h0000000F);
		bus(0, 16'h0000, 0);
		`CHK(rsp, 2'b10);
		rxFullSet <= 1'b1;
		@(posedge clk_sys);
		rxFullSet <= 1'b0;
		bus(0, 16'h40B8, 0);
		`CHK(rd[5], 1'b1);
		bus(0, 16'h40BC, 0);
		`CHK(rd[7:0], 8'hA5);
		bus(0, 16'h40B8, 0);
		`CHK(rd[5], 1'b0);
		bus(0, 16'h4094, 0);
		`CHK(rd[6], 1'b1);
		fail(1'b0);
		`CHK(resetReq, 1'b0);
		bus(1, 16'h4098, 3);
		bus(0, 16'h4098, 0);
		`CHK(rd, 32'h00000003);
		bus(1, 16'h4100, 32'h0007FDFF);
		for (i = 0; i < 14; i++)
		begin
			drv(rows[i][38:16]);
			repeat (4) @(posedge clk_sys);
			`CHK({vectorValid, vectorAddr}, {1'b1, rows[i][15:0]});
		end
		// Promotion written masked, above top channel
		for (i = 0; i < 5; i++)
		begin
			drv(23'h780000);
			bus(1, 16'h40F0, i);
			drv(23'h700080 | (23'h200 << i));
			repeat (4) @(posedge clk_sys);
			`CHK(vectorAddr, 16'hFFDE - 16'(2 * i));
		end
		drv(23'h780000);
		bus(1, 16'h40F0, 32'h0000000F);
		drv(23'h700081);
		repeat (4) @(posedge clk_sys);
		`CHK(vectorAddr, 16'hFFE0);
		ackOn <= 1'b0;
		fail(1'b1);
		`CHK(resetReq, 1'b1);
		rst(1'b1, 1'b0);
		`CHK(vectorAddr, 16'hFFFC);
		ackOn <= 1'b1;
		bus(0, 16'h40FC, 0);
		`CHK(rd, 32'h00000002);
		`CHK(cfgPins, 4'h2);
		bus(1, 16'h40FC, 32'h0000000F);
		ackOn <= 1'b0;
		fail(1'b0);
		`CHK(resetReq, 1'b1);
		rst(1'b1, 1'b0);
		`CHK(vectorAddr, 16'hFFFA);
		bus(0, 16'h40FC, 0);
		`CHK(rd, 32'h00000002);
		closeOut(1'b0);
	end
endmodule // test_rivu_top
